// [core/bvs_defines.svh]
// Register map, field positions, reset values and timing for the buck voltage control
`ifndef BVS_DEFINES_SVH
`define BVS_DEFINES_SVH
`define BVS_CLK_PERIOD_NS 25
`define BVS_SLEW0_NS 4000
`define BVS_SLEW1_NS 2000
`define BVS_SLEW2_NS 1000
`define BVS_SLEW3_NS 500
`define BVS_START0_NS 8000
`define BVS_START1_NS 4000
`define BVS_START2_NS 2000
`define BVS_START3_NS 1000
`define BVS_MASK_UNIT_NS 1000
`define BVS_ADDR_CTRL 12'h000
`define BVS_ADDR_EVENT 12'h004
`define BVS_ADDR_MASK 12'h008
`define BVS_ADDR_STATUS 12'h00c
`define BVS_ADDR_BUCK_A 12'h0d0
`define BVS_ADDR_BUCK_B 12'h0e0
`define BVS_LOCK_LO 12'h0d0
`define BVS_LOCK_HI 12'h14f
`define BVS_REG_PRESET1 2'h0
`define BVS_REG_PRESET2 2'h1
`define BVS_REG_CEIL 2'h2
`define BVS_REG_CFG 2'h3
`define BVS_CTRL_LOCK 0
`define BVS_CTRL_TRACK 1
`define BVS_CTRL_TPIN 2
`define BVS_CFG_MODE 0
`define BVS_CFG_SEL 2
`define BVS_CFG_SLEW 3
`define BVS_CFG_START 5
`define BVS_CFG_DOWN 7
`define BVS_CFG_PDOFF 9
`define BVS_CFG_SWEN 10
`define BVS_CFG_PINEN 11
`define BVS_CFG_PINSEL 13
`define BVS_CFG_OCMASK 15
`define BVS_CFG_MTIME 16
`define BVS_CFG_SL1 20
`define BVS_CFG_SL2 21
`define BVS_CFG_USED 32'h003f_ffff
`define BVS_EV_OC 0
`define BVS_EV_DONE 2
`define BVS_EV_GPI 4
`define BVS_EV_W 7
`define BVS_PRESET_RST 8'h46
`define BVS_CEIL_RST 8'h7f
`define BVS_CFG_RST 32'h0000_0000
`define BVS_RESP_OKAY 2'h0
`define BVS_RESP_SLVERR 2'h2
`endif

// [core/bvs_pkg.sv]
// Types shared by the buck voltage control modules
package bvs_pkg;
  typedef enum logic [1:0] {RS_OFF, RS_START, RS_RUN, RS_DOWN} bvs_ramp_state_t;
endpackage

// [core/bvs_ramp.sv]
// Per-buck voltage ramp engine: soft start, voltage transitions, ramped power-down
`timescale 1ns/10ps
`include "bvs_defines.svh"
module bvs_ramp import bvs_pkg::*; #(
  parameter int CW = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic enable_i,
  input wire logic [7:0] target_i,
  input wire logic [1:0] slew_sel_i,
  input wire logic [1:0] start_sel_i,
  input wire logic [1:0] down_sel_i,
  input wire logic [3:0] mask_time_i,
  // Status
  output logic [7:0] vout_o,
  output logic ramping_o,
  output logic mask_window_o,
  output logic on_o,
  output logic done_o
);
  localparam logic [CW-1:0] SLEW0 = CW'(`BVS_SLEW0_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] SLEW1 = CW'(`BVS_SLEW1_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] SLEW2 = CW'(`BVS_SLEW2_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] SLEW3 = CW'(`BVS_SLEW3_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] START0 = CW'(`BVS_START0_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] START1 = CW'(`BVS_START1_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] START2 = CW'(`BVS_START2_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] START3 = CW'(`BVS_START3_NS / `BVS_CLK_PERIOD_NS);
  localparam logic [CW-1:0] MUNIT = CW'(`BVS_MASK_UNIT_NS / `BVS_CLK_PERIOD_NS);

  bvs_ramp_state_t state;
  logic [CW-1:0] cnt;
  logic [CW-1:0] interval;
  logic [CW-1:0] mcnt;
  logic [7:0] goal;
  logic moving;
  logic tick;

  always_comb begin
    interval = SLEW0;
    if (state == RS_START) begin
      unique case (start_sel_i)
        2'h0: interval = START0;
        2'h1: interval = START1;
        2'h2: interval = START2;
        2'h3: interval = START3;
      endcase
    end else begin
      unique case (state == RS_DOWN ? down_sel_i : slew_sel_i)
        2'h0: interval = SLEW0;
        2'h1: interval = SLEW1;
        2'h2: interval = SLEW2;
        2'h3: interval = SLEW3;
      endcase
    end
  end

  assign goal = (state == RS_DOWN) ? 8'h00 : target_i;
  assign moving = (state != RS_OFF) && (vout_o != goal);
  assign tick = moving && (cnt == interval - CW'(1));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
    end else if (!moving || tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + CW'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RS_OFF;
    end else begin
      unique case (state)
        RS_OFF: if (enable_i) state <= RS_START;
        RS_START, RS_RUN: begin
          // No ramp selected: drop at once, the pull-down does the rest
          if (!enable_i) state <= (down_sel_i == 2'h0) ? RS_OFF : RS_DOWN;
          else if (state == RS_START && vout_o == target_i) state <= RS_RUN;
        end
        RS_DOWN: begin
          if (enable_i) state <= RS_START;
          else if (vout_o == 8'h00) state <= RS_OFF;
        end
      endcase
    end
  end

  // One 10 mV code step per interval
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vout_o <= 8'h00;
    end else if (state == RS_OFF) begin
      vout_o <= 8'h00;
    end else if (tick) begin
      vout_o <= (vout_o < goal) ? vout_o + 8'h01 : vout_o - 8'h01;
    end
  end

  // Extra over-current masking time after every transition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcnt <= '0;
      mask_window_o <= 1'b0;
    end else begin
      mcnt <= moving ? CW'(mask_time_i) * MUNIT : (mcnt != '0 ? mcnt - CW'(1) : mcnt);
      mask_window_o <= moving || (mcnt != '0);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ramping_o <= 1'b0;
      done_o <= 1'b0;
      on_o <= 1'b0;
    end else begin
      ramping_o <= moving;
      done_o <= ramping_o && !moving;
      on_o <= (state != RS_OFF);
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  step_size_a: assert property ($changed(vout_o) && $past(state) != RS_OFF |->
    (vout_o == $past(vout_o) + 8'h01) || (vout_o == $past(vout_o) - 8'h01))
    else $error("output code moved by more than one step");
  ramp_flag_a: assert property (moving |=> ramping_o)
    else $error("ramp indication missing during transition");
  sequence ramp_ends;
    ramping_o ##1 !ramping_o;
  endsequence
  ramp_done_a: assert property (ramp_ends |-> done_o)
    else $error("ramp done pulse missing");
  mask_extend_a: assert property ($fell(ramping_o) && mask_time_i != 4'h0 |-> mask_window_o)
    else $error("over-current mask window not extended");
endmodule

// [core/bvs_top.sv]
// Buck voltage selection control with AXI4-Lite register access
//
// Contract
// - Voltage lock set: every write to addresses 0xD0 through 0x14F is blocked.
// - Each buck holds two presets; select toggle or selected preset rewrite changes target.
// - Every target change ramps; ramp indication is high throughout the ramp.
// - On enable a buck targets its first preset unless pin selection is configured.
// - Operating mode 00: the selected preset also picks PWM or PFM operation.
// - Commanded voltage is clamped to the buck's ceiling register.
// - Optional hardware enable from an input pin chosen by pin-enable bits.
// - With pin selection on, each pin edge reselects preset by pin level.
// - Track mode: buck A target follows the voltage code at the input port.
// - Track mode ignores buck A select bit and presets, resumed when disabled.
// - An input port assigned to track mode raises no event.
// - After enable each buck soft-starts at its own start-up rate.
// - Selectable ramped power-down; otherwise pull-down discharge unless pull-down is off.
// - Current limit sets over-current event and interrupt unless masked.
// - Over-current mask suppresses events during transitions plus configured extra time.
// - Ramp steps 10 mV every 4, 2, 1 or 0.5 us, set per buck.
// - Ramp done reports only completion of the digital ramp.
`timescale 1ns/10ps
`include "bvs_defines.svh"
module bvs_top import bvs_pkg::*; #(
  parameter int AW = 12,
  parameter int NPIN = 3
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // AXI4-Lite write
  input wire logic [AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read
  input wire logic [AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Device inputs
  input wire logic [NPIN-1:0] gpi_i,
  input wire logic [7:0] track_code_i,
  input wire logic [1:0] oc_i,
  // Buck outputs
  output logic [1:0][7:0] vout_o,
  output logic [1:0] ramping_o,
  output logic [1:0] ramp_done_o,
  output logic [1:0] buck_on_o,
  output logic [1:0] pfm_o,
  output logic [1:0] pulldown_o,
  output logic irq_o
);
  logic [3:0] ctrl;
  logic [1:0][7:0] preset1;
  logic [1:0][7:0] preset2;
  logic [1:0][7:0] ceil;
  logic [1:0][31:0] cfg;
  logic [`BVS_EV_W-1:0] status;
  logic [`BVS_EV_W-1:0] mask;
  logic [`BVS_EV_W-1:0] next_status;
  logic [`BVS_EV_W-1:0] next_mask;
  logic [`BVS_EV_W-1:0] ev_set;
  logic [`BVS_EV_W-1:0] ev_clr;
  logic [NPIN-1:0] gpi_q;
  logic [1:0] eff_en;
  logic [1:0] en_q;
  logic [1:0] eff_sel;
  logic [1:0][7:0] target;
  logic [1:0] mask_window;
  logic track_en;

  // Bus state
  logic [AW-1:0] aw_addr;
  logic aw_full;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_full;
  logic wr_go;
  logic locked_hit;
  logic next_aw_full;
  logic next_w_full;
  logic next_rvalid;
  logic [31:0] rd_val;
  logic rd_ok;
  logic wr_ok;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction

  function automatic logic is_buck(input logic [AW-1:0] a, output logic b, output logic [1:0] r);
    b = (a[AW-1:4] == `BVS_ADDR_BUCK_B >> 4);
    r = a[3:2];
    return (a[AW-1:4] == `BVS_ADDR_BUCK_A >> 4) || b;
  endfunction

  assign track_en = ctrl[`BVS_CTRL_TRACK];
  assign wr_go = aw_full && w_full && !s_axi_bvalid_o;
  assign locked_hit = ctrl[`BVS_CTRL_LOCK] && aw_addr >= `BVS_LOCK_LO &&
                      aw_addr <= `BVS_LOCK_HI;
  assign next_aw_full = wr_go ? 1'b0 : (aw_full || (s_axi_awvalid_i && s_axi_awready_o));
  assign next_w_full = wr_go ? 1'b0 : (w_full || (s_axi_wvalid_i && s_axi_wready_o));
  assign next_rvalid = (s_axi_arvalid_i && s_axi_arready_o) ? 1'b1 :
                       (s_axi_rvalid_o && !s_axi_rready_i ? 1'b1 : 1'b0);

  // Write address and data may arrive in either order
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `BVS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) aw_addr <= s_axi_awaddr_i;
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      s_axi_awready_o <= !next_aw_full;
      s_axi_wready_o <= !next_w_full;
      if (wr_go) begin
        s_axi_bvalid_o <= 1'b1;
        // Locked writes are dropped silently, never flagged as errors
        s_axi_bresp_o <= (wr_ok || locked_hit) ? `BVS_RESP_OKAY : `BVS_RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  always_comb begin
    logic b;
    logic [1:0] r;
    b = 1'b0;
    r = 2'h0;
    wr_ok = is_buck(aw_addr, b, r) || aw_addr == `BVS_ADDR_CTRL ||
            aw_addr == `BVS_ADDR_EVENT || aw_addr == `BVS_ADDR_MASK ||
            aw_addr == `BVS_ADDR_STATUS;
  end

  always_comb begin
    logic b;
    logic [1:0] r;
    b = 1'b0;
    r = 2'h0;
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (is_buck(s_axi_araddr_i, b, r)) begin
      unique case (r)
        `BVS_REG_PRESET1: rd_val = {24'h00_0000, preset1[b]};
        `BVS_REG_PRESET2: rd_val = {24'h00_0000, preset2[b]};
        `BVS_REG_CEIL: rd_val = {24'h00_0000, ceil[b]};
        `BVS_REG_CFG: rd_val = cfg[b];
      endcase
    end else if (s_axi_araddr_i == `BVS_ADDR_CTRL) begin
      rd_val = {28'h000_0000, ctrl};
    end else if (s_axi_araddr_i == `BVS_ADDR_EVENT) begin
      rd_val = {25'h000_0000, status};
    end else if (s_axi_araddr_i == `BVS_ADDR_MASK) begin
      rd_val = {25'h000_0000, mask};
    end else if (s_axi_araddr_i == `BVS_ADDR_STATUS) begin
      rd_val = {16'h0000, target[1], target[0]} | {24'h00_0000, pfm_o, buck_on_o, ramping_o, 2'h0};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `BVS_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i && s_axi_arready_o) begin
        s_axi_rdata_o <= rd_val;
        s_axi_rresp_o <= rd_ok ? `BVS_RESP_OKAY : `BVS_RESP_SLVERR;
      end
      s_axi_rvalid_o <= next_rvalid;
      s_axi_arready_o <= !next_rvalid;
    end
  end

  // Configuration registers
  always_ff @(posedge clk_i) begin
    logic b;
    logic [1:0] r;
    b = 1'b0;
    r = 2'h0;
    if (rst_i) begin
      ctrl <= 4'h0;
      mask <= '0;
      preset1 <= {2{`BVS_PRESET_RST}};
      preset2 <= {2{`BVS_PRESET_RST}};
      ceil <= {2{`BVS_CEIL_RST}};
      cfg <= {2{`BVS_CFG_RST}};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (eff_en[i] && !en_q[i] && cfg[i][`BVS_CFG_PINSEL +: 2] == 2'h0) begin
          cfg[i][`BVS_CFG_SEL] <= 1'b0;
        end
      end
      if (wr_go && !locked_hit) begin
        if (is_buck(aw_addr, b, r)) begin
          unique case (r)
            // Narrow registers sit wholly in byte lane 0
            `BVS_REG_PRESET1: if (w_strb[0]) preset1[b] <= w_data[7:0];
            `BVS_REG_PRESET2: if (w_strb[0]) preset2[b] <= w_data[7:0];
            `BVS_REG_CEIL: if (w_strb[0]) ceil[b] <= w_data[7:0];
            `BVS_REG_CFG: cfg[b] <= merge(cfg[b], w_data, w_strb) & `BVS_CFG_USED;
          endcase
        end else if (aw_addr == `BVS_ADDR_CTRL) begin
          if (w_strb[0]) ctrl <= w_data[3:0];
        end else if (aw_addr == `BVS_ADDR_MASK) begin
          mask <= next_mask;
        end
      end
    end
  end

  // Event bits: a new event wins over a simultaneous clear
  always_comb begin
    ev_clr = '0;
    if (wr_go && aw_addr == `BVS_ADDR_EVENT && w_strb[0]) ev_clr = w_data[`BVS_EV_W-1:0];
    next_status = (status & ~ev_clr) | ev_set;
    // Interrupt follows a mask write in the same cycle as the mask itself
    next_mask = mask;
    if (wr_go && aw_addr == `BVS_ADDR_MASK && w_strb[0]) next_mask = w_data[`BVS_EV_W-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
      irq_o <= 1'b0;
      gpi_q <= '0;
      en_q <= 2'h0;
    end else begin
      status <= next_status;
      irq_o <= |(next_status & next_mask);
      gpi_q <= gpi_i;
      en_q <= eff_en;
    end
  end

  genvar p;
  generate
    for (p = 0; p < NPIN; p++) begin : g_pin
      // A pin used for tracking is an analog input and never raises an event
      assign ev_set[`BVS_EV_GPI + p] = (gpi_i[p] != gpi_q[p]) &&
        !(track_en && ctrl[`BVS_CTRL_TPIN +: 2] == 2'(p + 1));
    end
  endgenerate

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_buck
      logic [1:0] pin_en;
      logic [1:0] pin_sel;
      logic [7:0] raw;
      logic oc_block;
      assign pin_en = cfg[k][`BVS_CFG_PINEN +: 2];
      assign pin_sel = cfg[k][`BVS_CFG_PINSEL +: 2];
      assign eff_en[k] = (pin_en == 2'h0) ? cfg[k][`BVS_CFG_SWEN] : gpi_q[pin_en - 2'h1];
      // Pin copy changes only on an edge, so every edge reselects
      assign eff_sel[k] = (pin_sel == 2'h0) ? cfg[k][`BVS_CFG_SEL] : gpi_q[pin_sel - 2'h1];
      if (k == 0) begin : g_track
        assign raw = track_en ? track_code_i : (eff_sel[k] ? preset2[k] : preset1[k]);
      end else begin : g_plain
        assign raw = eff_sel[k] ? preset2[k] : preset1[k];
      end
      assign target[k] = (raw > ceil[k]) ? ceil[k] : raw;
      assign oc_block = cfg[k][`BVS_CFG_OCMASK] && mask_window[k];
      assign ev_set[`BVS_EV_OC + k] = oc_i[k] && !oc_block;
      assign ev_set[`BVS_EV_DONE + k] = ramp_done_o[k];

      bvs_ramp u_ramp (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(eff_en[k]),
        .target_i(target[k]),
        .slew_sel_i(cfg[k][`BVS_CFG_SLEW +: 2]),
        .start_sel_i(cfg[k][`BVS_CFG_START +: 2]),
        .down_sel_i(cfg[k][`BVS_CFG_DOWN +: 2]),
        .mask_time_i(cfg[k][`BVS_CFG_MTIME +: 4]),
        .vout_o(vout_o[k]),
        .ramping_o(ramping_o[k]),
        .mask_window_o(mask_window[k]),
        .on_o(buck_on_o[k]),
        .done_o(ramp_done_o[k])
      );

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pfm_o[k] <= 1'b0;
          pulldown_o[k] <= 1'b0;
        end else begin
          unique case (cfg[k][`BVS_CFG_MODE +: 2])
            2'h0: pfm_o[k] <= eff_sel[k] ? cfg[k][`BVS_CFG_SL2] : cfg[k][`BVS_CFG_SL1];
            2'h2: pfm_o[k] <= 1'b1;
            default: pfm_o[k] <= 1'b0;
          endcase
          pulldown_o[k] <= !eff_en[k] && !cfg[k][`BVS_CFG_PDOFF];
        end
      end

      oc_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
        oc_i[k] && !oc_block |=> status[`BVS_EV_OC + k])
        else $error("over-current event not raised");
      oc_suppress_a: assert property (@(posedge clk_i) disable iff (rst_i)
        oc_i[k] && oc_block && !status[`BVS_EV_OC + k] |=> !status[`BVS_EV_OC + k])
        else $error("over-current event raised inside mask window");
      ceiling_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
        target[k] <= ceil[k] && (raw <= ceil[k] -> target[k] == raw))
        else $error("target not clamped to ceiling");
      pfm_select_a: assert property (@(posedge clk_i) disable iff (rst_i)
        cfg[k][`BVS_CFG_MODE +: 2] == 2'h0 |=>
        pfm_o[k] == ($past(eff_sel[k]) ? $past(cfg[k][`BVS_CFG_SL2]) :
        $past(cfg[k][`BVS_CFG_SL1])))
        else $error("mode 00 preset does not pick PWM or PFM");
    end
  endgenerate

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence locked_write;
    wr_go && locked_hit;
  endsequence
  lock_block_a: assert property (locked_write |=> preset1 == $past(preset1) &&
    preset2 == $past(preset2) && ceil == $past(ceil))
    else $error("locked register was written");
  lock_okay_a: assert property (locked_write |=> s_axi_bvalid_o &&
    s_axi_bresp_o == `BVS_RESP_OKAY)
    else $error("locked write not answered OKAY");
  track_follow_a: assert property (track_en && track_code_i <= ceil[0] |->
    target[0] == track_code_i)
    else $error("buck A target does not follow track input");
  irq_level_a: assert property (irq_o == |(status & mask))
    else $error("interrupt output disagrees with unmasked events");
endmodule

// [verif/bvs_host.sv]
// Behavioural AXI4-Lite host that stands in for the processor
`timescale 1ns/10ps
module bvs_host (
  // Clock
  input wire logic clk_i,
  // Write channels
  output logic [11:0] awaddr_o,
  output logic awvalid_o,
  input wire logic awready_i,
  output logic [31:0] wdata_o,
  output logic [3:0] wstrb_o,
  output logic wvalid_o,
  input wire logic wready_i,
  input wire logic [1:0] bresp_i,
  input wire logic bvalid_i,
  output logic bready_o,
  // Read channels
  output logic [11:0] araddr_o,
  output logic arvalid_o,
  input wire logic arready_i,
  input wire logic [31:0] rdata_i,
  input wire logic [1:0] rresp_i,
  input wire logic rvalid_i,
  output logic rready_o
);
  initial begin
    {awaddr_o, awvalid_o, wdata_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
    wstrb_o = 4'hf;
  end
  // Address and data offered together, each released once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_i);
    awaddr_o <= a;
    awvalid_o <= 1'b1;
    wdata_o <= d;
    wvalid_o <= 1'b1;
    bready_o <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk_i);
      if (!aw_done && awready_i) begin
        aw_done = 1'b1;
        awvalid_o <= 1'b0;
      end
      if (!w_done && wready_i) begin
        w_done = 1'b1;
        wvalid_o <= 1'b0;
      end
    end
    while (!bvalid_i) @(posedge clk_i);
    r = bresp_i;
    bready_o <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_i);
    araddr_o <= a;
    arvalid_o <= 1'b1;
    rready_o <= 1'b1;
    do @(posedge clk_i); while (!arready_i);
    arvalid_o <= 1'b0;
    while (!rvalid_i) @(posedge clk_i);
    d = rdata_i;
    r = rresp_i;
    rready_o <= 1'b0;
  endtask
endmodule

// [verif/bvs_top_tb.sv]
// Self-checking bench for the buck voltage control block
`timescale 1ns/10ps
module bvs_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] gpi_i = 3'h0;
  logic [7:0] track_code_i = 8'h00;
  logic [1:0] oc_i = 2'h0;
  logic [11:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, ramping, done, on, pfm, pd;
  logic [1:0][7:0] vout;
  logic irq;
  int bad_count = 0;
  int comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  bvs_host u_host (.clk_i(clk_i), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb), .wvalid_o(wvalid),
    .wready_i(wready), .bresp_i(bresp), .bvalid_i(bvalid), .bready_o(bready),
    .araddr_o(araddr), .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));
  bvs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .gpi_i(gpi_i), .track_code_i(track_code_i), .oc_i(oc_i),
    .vout_o(vout), .ramping_o(ramping), .ramp_done_o(done), .buck_on_o(on),
    .pfm_o(pfm), .pulldown_o(pd), .irq_o(irq));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    u_host.wr(a, d, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    u_host.rd(a, d, r);
    chk("rresp", {30'h0, er}, {30'h0, r});
    chk("rdata", e, d);
  endtask
  // Counts ramping cycles until the done pulse, bounded
  task automatic ramp(input int b, output int n);
    n = 0;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk_i);
      if (done[b] === 1'b1) break;
      if (ramping[b] === 1'b1) n++;
    end
    // Events raised by the done pulse settle one edge later
    @(posedge clk_i);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic pulse_oc(input logic [1:0] v);
    @(posedge clk_i);
    oc_i <= v;
    @(posedge clk_i);
    oc_i <= 2'h0;
  endtask
  task automatic close_out;
    $display("Counts: comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Whole run needs well under 5000 cycles
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    $display("BAD watchdog expected finish seen hang");
    close_out();
  end
  initial begin
    int n;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(12'h0d0, 32'h46, 2'h0);
    rd(12'h0d4, 32'h46, 2'h0);
    rd(12'h0d8, 32'h7f, 2'h0);
    rd(12'h0ec, 32'h0, 2'h0);
    rd(12'hffc, 32'h0, 2'h2);
    wr(12'hffc, 32'h1, 2'h2);
    $display("Test reset_map done");
    wr(12'h008, 32'h7f, 2'h0);
    wr(12'h0d0, 32'h08, 2'h0);
    wr(12'h0dc, 32'h0020_0478, 2'h0);
    ramp(0, n);
    chk("vout_a", 32'h08, {24'h0, vout[0]});
    chk("on_a", 32'h1, {31'h0, on[0]});
    chk("pfm_a", 32'h0, {31'h0, pfm[0]});
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h004, 32'h7f, 2'h0);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    $display("Test soft_start done");
    wr(12'h0d4, 32'h0c, 2'h0);
    wr(12'h0dc, 32'h0020_847c, 2'h0);
    pulse_oc(2'h1);
    ramp(0, n);
    chk("ramp_len", 32'h1, {31'h0, n >= 78 && n <= 82});
    chk("vout_a", 32'h0c, {24'h0, vout[0]});
    chk("pfm_a", 32'h1, {31'h0, pfm[0]});
    rd(12'h004, 32'h04, 2'h0);
    wr(12'h004, 32'h7f, 2'h0);
    $display("Test select_toggle done");
    wr(12'h008, 32'h7d, 2'h0);
    pulse_oc(2'h2);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    rd(12'h004, 32'h02, 2'h0);
    wr(12'h008, 32'h7f, 2'h0);
    cyc(2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h004, 32'h7f, 2'h0);
    cyc(2);
    chk("irq", 32'h0, {31'h0, irq});
    $display("Test overcurrent done");
    wr(12'h0d8, 32'h0e, 2'h0);
    wr(12'h0d4, 32'h20, 2'h0);
    ramp(0, n);
    chk("vout_a", 32'h0e, {24'h0, vout[0]});
    wr(12'h000, 32'h1, 2'h0);
    wr(12'h0d0, 32'h33, 2'h0);
    wr(12'h0d8, 32'h7f, 2'h0);
    rd(12'h0d0, 32'h08, 2'h0);
    rd(12'h0d8, 32'h0e, 2'h0);
    wr(12'h000, 32'h0, 2'h0);
    $display("Test clamp_lock done");
    track_code_i <= 8'h05;
    wr(12'h000, 32'h6, 2'h0);
    gpi_i <= 3'h1;
    wr(12'h0d4, 32'h0d, 2'h0);
    ramp(0, n);
    chk("vout_a", 32'h05, {24'h0, vout[0]});
    rd(12'h004, 32'h04, 2'h0);
    wr(12'h004, 32'h7f, 2'h0);
    wr(12'h000, 32'h0, 2'h0);
    ramp(0, n);
    chk("vout_a", 32'h0d, {24'h0, vout[0]});
    $display("Test track done");
    wr(12'h0e0, 32'h04, 2'h0);
    wr(12'h0e4, 32'h06, 2'h0);
    wr(12'h0ec, 32'h0000_5860, 2'h0);
    @(posedge clk_i);
    gpi_i <= 3'h5;
    ramp(1, n);
    chk("on_b", 32'h1, {31'h0, on[1]});
    chk("vout_b", 32'h04, {24'h0, vout[1]});
    @(posedge clk_i);
    gpi_i <= 3'h7;
    ramp(1, n);
    chk("vout_b", 32'h06, {24'h0, vout[1]});
    @(posedge clk_i);
    gpi_i <= 3'h3;
    cyc(4);
    chk("on_b", 32'h0, {31'h0, on[1]});
    chk("pd_b", 32'h1, {31'h0, pd[1]});
    chk("vout_b", 32'h0, {24'h0, vout[1]});
    $display("Test pin_control done");
    wr(12'h0dc, 32'h0020_80fc, 2'h0);
    ramp(0, n);
    chk("down_len", 32'h1, {31'h0, n >= 1038 && n <= 1042});
    chk("vout_a", 32'h0, {24'h0, vout[0]});
    chk("on_a", 32'h0, {31'h0, on[0]});
    chk("pd_a", 32'h1, {31'h0, pd[0]});
    $display("Test power_down done");
    close_out();
  end
endmodule
